// [adc_config_word_register.sv]
// What this block does
// RULE1 - one sixteen-bit word holds every option
// RULE2 - host shifts word in; commit at conversion end
// RULE3 - written word governs conversion two later
// RULE4 - reset release loads the default word
// RULE5 - power-down exit keeps user word, two dummies
// RULE6 - reset value is 8fcf
// RULE7 - default fields meaning per documented list
// RULE8 - field layout from bit fifteen down
// RULE9 - update bit zero keeps current word
// RULE10 - channel field picks input in binary
// RULE11 - pairing bit: pairs or shared sense
// RULE12 - spare bit has no effect
// RULE13 - range scope depends on scan mode
// RULE14 - range codes decode to full scale
// RULE15 - source bit picks auxiliary pair or mux
// RULE16 - output phase controls first bit timing
// RULE17 - readback word follows result for sixteen clocks
// RULE18 - middle channel codes map in order
`timescale 1ns/1ns
`default_nettype none
module adc_config_word_register
	import config_word_pkg::*;
#(
	parameter int WORD_WIDTH = CFG_WIDTH
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic linkClock,
	input wire logic chipSelectN,
	input wire logic serialIn,
	output logic serialOut,
	input wire logic resetPin,
	input wire logic powerDownPin,
	input wire logic endOfConversion,
	input wire logic [15:0] conversionResult,
	output logic [15:0] activeWord,
	output logic [15:0] readbackWord,
	output logic wordPending,
	output logic [2:0] channelSelect,
	output logic pairingSelect,
	output logic [2:0] positiveInput,
	output logic [2:0] negativeInput,
	output logic negativeIsSense,
	output logic auxSelected,
	output logic [2:0] inputRangeSelect,
	output logic [14:0] rangeFullScaleMv,
	output logic rangeAllChannels,
	output logic sourceSelect,
	output logic [1:0] scanMode,
	output logic tempSensorOff,
	output logic internalReferenceOn,
	output logic conversionModeSelect,
	output logic outputPhaseSelect
);
	generate
		if (WORD_WIDTH != 16) begin : g_bad
			$error("configuration word must be sixteen bits");
		end
	endgenerate

	// ****************************************
	// functions
	// ****************************************
	function automatic logic [14:0] fullScale(input logic [2:0] code);
		logic [14:0] fs;
		fs = FS_NONE;
		case (code)
			3'h0: fs = FS_24576; // [RULE14]
			3'h1: fs = FS_10240;
			3'h2: fs = FS_5120;
			3'h3: fs = FS_2560;
			3'h4: fs = FS_1280;
			3'h5: fs = FS_640;
			3'h7: fs = FS_20480;
			default: fs = FS_NONE;
		endcase
		return fs;
	endfunction

	function automatic logic rangeUsable(input logic [2:0] code);
		return code != RANGE_UNUSED; // [RULE14]
	endfunction

	// ****************************************
	// link capture and crossings
	// ****************************************
	config_shift_if shiftBus();

	config_shift_capture capture (
		.linkClock(linkClock),
		.resetn(resetn),
		.chipSelectN(chipSelectN),
		.serialIn(serialIn),
		.bus(shiftBus.link)
	);

	logic [4:0] pinSync;
	// select enters inverted so a cleared synchroniser reads as deselected, no false frame start
	bit_sync #(.WIDTH(5)) pinSyncer (
		.clock(clock),
		.resetn(resetn),
		.asyncIn({shiftBus.wordToggle, linkClock, ~chipSelectN, resetPin, powerDownPin}),
		.syncOut(pinSync)
	);

	logic toggleSync;
	logic sckSync;
	logic csnSync;
	logic resetSync;
	logic powerDownSync;
	assign toggleSync = pinSync[4];
	assign sckSync = pinSync[3];
	assign csnSync = ~pinSync[2];
	assign resetSync = pinSync[1];
	assign powerDownSync = pinSync[0];

	logic togglePrev;
	logic sckPrev;
	logic csnPrev;
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			togglePrev <= 1'b0;
			sckPrev <= 1'b0;
			csnPrev <= 1'b1;
		end else begin
			togglePrev <= toggleSync;
			sckPrev <= sckSync;
			csnPrev <= csnSync;
		end
	end

	logic wordArrived;
	logic sckFall;
	logic frameStart;
	assign wordArrived = toggleSync != togglePrev;
	assign sckFall = sckPrev & ~sckSync;
	assign frameStart = csnPrev & ~csnSync;

	// ****************************************
	// pending word
	// ****************************************
	// the shifted word is stable for a full link period after the toggle
	logic [15:0] pendingWord;
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pendingWord <= CFG_RESET;
		end else if (wordArrived) begin
			pendingWord <= shiftBus.word; // [RULE2]
		end
	end

	// a new arrival in the commit cycle wins over the clear
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			wordPending <= 1'b0;
		end else if (resetSync) begin
			wordPending <= 1'b0;
		end else if (wordArrived) begin
			wordPending <= 1'b1;
		end else if (endOfConversion && !powerDownSync) begin
			wordPending <= 1'b0; // [RULE2]
		end
	end

	// ****************************************
	// two-deep configuration pipeline
	// ****************************************
	logic commitNow;
	logic [15:0] stagedWord;
	logic [15:0] next_stagedWord;
	logic [15:0] next_activeWord;
	// power-down freezes both stages; dummy conversions then push the user word through
	assign commitNow = endOfConversion & ~powerDownSync & ~resetSync; // [RULE5]

	always_comb begin
		next_stagedWord = stagedWord;
		next_activeWord = activeWord;
		if (resetSync) begin
			next_stagedWord = CFG_RESET; // [RULE4] [RULE6]
			next_activeWord = CFG_RESET; // [RULE4] [RULE6]
		end else if (commitNow) begin
			next_activeWord = stagedWord; // [RULE3]
			if (wordPending && pendingWord[UPDATE_BIT]) begin
				next_stagedWord = pendingWord; // [RULE9]
			end
		end
	end

	// reset default also means: sense-referenced input zero, range code 7 (20480 full scale),
	// mux path, no scan, sensor off, reference on, normal mode
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			stagedWord <= CFG_RESET; // [RULE6] [RULE7]
		end else begin
			stagedWord <= next_stagedWord; // [RULE1] [RULE3]
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			activeWord <= CFG_RESET; // [RULE6] [RULE7]
		end else begin
			activeWord <= next_activeWord; // [RULE1] [RULE3]
		end
	end

	// ****************************************
	// field decode
	// ****************************************
	// spare bit is carried in the word and read back, but nothing decodes it
	logic [2:0] next_channel;
	logic next_pairing;
	logic next_source;
	logic [2:0] next_range;
	logic [1:0] next_scan;
	always_comb begin
		next_channel = next_activeWord[CHAN_HI:CHAN_LO]; // [RULE8] [RULE10] [RULE12]
		next_pairing = next_activeWord[PAIR_BIT]; // [RULE8]
		next_source = next_activeWord[SOURCE_BIT]; // [RULE8]
		next_range = next_activeWord[RANGE_HI:RANGE_LO]; // [RULE8]
		next_scan = next_activeWord[SCAN_HI:SCAN_LO]; // [RULE8]
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			channelSelect <= CFG_RESET[CHAN_HI:CHAN_LO];
			pairingSelect <= CFG_RESET[PAIR_BIT];
			sourceSelect <= CFG_RESET[SOURCE_BIT];
			inputRangeSelect <= CFG_RESET[RANGE_HI:RANGE_LO];
			scanMode <= CFG_RESET[SCAN_HI:SCAN_LO];
			tempSensorOff <= CFG_RESET[TEMP_BIT];
			internalReferenceOn <= CFG_RESET[REF_BIT];
			conversionModeSelect <= CFG_RESET[CONV_BIT];
			outputPhaseSelect <= CFG_RESET[PHASE_BIT];
		end else begin
			channelSelect <= next_channel; // [RULE10] [RULE18]
			pairingSelect <= next_pairing;
			sourceSelect <= next_source;
			inputRangeSelect <= next_range;
			scanMode <= next_scan;
			tempSensorOff <= next_activeWord[TEMP_BIT];
			internalReferenceOn <= next_activeWord[REF_BIT];
			conversionModeSelect <= next_activeWord[CONV_BIT];
			outputPhaseSelect <= next_activeWord[PHASE_BIT];
		end
	end

	// input routing: auxiliary pair never uses the shared sense
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			positiveInput <= 3'h0;
			negativeInput <= 3'h0;
			negativeIsSense <= 1'b1;
			auxSelected <= 1'b0;
		end else begin
			auxSelected <= ~next_source; // [RULE15]
			if (!next_source) begin
				positiveInput <= 3'h0;
				negativeInput <= 3'h0;
				negativeIsSense <= 1'b0; // [RULE11] [RULE15]
			end else if (next_pairing) begin
				positiveInput <= next_channel; // [RULE10] [RULE18]
				negativeInput <= 3'h0;
				negativeIsSense <= 1'b1; // [RULE11]
			end else begin
				positiveInput <= {next_channel[2:1], 1'b0}; // [RULE11]
				negativeInput <= {next_channel[2:1], 1'b1}; // [RULE11]
				negativeIsSense <= 1'b0;
			end
		end
	end

	// unused range code reads as zero full scale
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rangeFullScaleMv <= FS_20480;
			rangeAllChannels <= 1'b1;
		end else begin
			if (rangeUsable(next_range)) begin
				rangeFullScaleMv <= fullScale(next_range); // [RULE14]
			end else begin
				rangeFullScaleMv <= FS_NONE; // [RULE14]
			end
			// advanced scanning limits the field to input zero or the first pair
			rangeAllChannels <= next_scan != SCAN_ADVANCED; // [RULE13]
		end
	end

	// ****************************************
	// readback snapshot
	// ****************************************
	// the word returned is the one that governed the conversion just ended
	logic [15:0] readResult;
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			readResult <= 16'h0000;
			readbackWord <= CFG_RESET;
		end else if (commitNow) begin
			readResult <= conversionResult;
			readbackWord <= activeWord; // [RULE3] [RULE17]
		end
	end

	// ****************************************
	// serial output
	// ****************************************
	readback_state_t linkState;
	logic [4:0] bitIndex;
	logic [31:0] frameBits;
	assign frameBits = {readResult, readbackWord}; // [RULE17]

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			linkState <= LINK_IDLE;
		end else if (csnSync) begin
			linkState <= LINK_IDLE;
		end else begin
			case (linkState)
				LINK_IDLE: begin
					if (frameStart) begin
						linkState <= outputPhaseSelect ? LINK_PHASE_HOLD : LINK_SHIFT; // [RULE16]
					end
				end
				LINK_PHASE_HOLD: begin
					if (sckFall) begin
						linkState <= LINK_SHIFT;
					end
				end
				LINK_SHIFT: linkState <= LINK_SHIFT;
				default: linkState <= LINK_IDLE;
			endcase
		end
	end

	// wraps after both words, so further edges repeat result and word
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			bitIndex <= 5'h00;
		end else if (csnSync || frameStart) begin
			bitIndex <= 5'h00;
		end else if (linkState == LINK_SHIFT && sckFall) begin
			bitIndex <= bitIndex + 5'h01; // [RULE16] [RULE17]
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			serialOut <= 1'b0;
		end else if (csnSync) begin
			serialOut <= 1'b0;
		end else if (frameStart) begin
			serialOut <= frameBits[FRAME_LAST_BIT]; // [RULE16]
		end else if (linkState == LINK_PHASE_HOLD && sckFall) begin
			serialOut <= frameBits[FRAME_LAST_BIT]; // [RULE16]
		end else if (linkState == LINK_SHIFT && sckFall) begin
			serialOut <= frameBits[FRAME_LAST_BIT - (bitIndex + 5'h01)]; // [RULE17]
		end
	end
endmodule
`default_nettype wire

// [adc_config_word_register_assertions.sv]
`timescale 1ns/1ns
`default_nettype none
// ********
// port checks
// ********
module adc_config_word_checker
	import config_word_pkg::*;
(
	input wire logic clock,
	input wire logic resetn,
	input wire logic chipSelectN,
	input wire logic serialOut,
	input wire logic resetPin,
	input wire logic powerDownPin,
	input wire logic endOfConversion,
	input wire logic [15:0] activeWord,
	input wire logic [2:0] channelSelect,
	input wire logic pairingSelect,
	input wire logic [2:0] positiveInput,
	input wire logic negativeIsSense,
	input wire logic auxSelected,
	input wire logic [2:0] inputRangeSelect,
	input wire logic [14:0] rangeFullScaleMv,
	input wire logic rangeAllChannels,
	input wire logic sourceSelect,
	input wire logic [1:0] scanMode
);
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	a_word_fields: assert property (
		{channelSelect, pairingSelect, inputRangeSelect, sourceSelect, scanMode}
		== {activeWord[14:11], activeWord[9:4]}) else $error("fields differ from word");
	a_reset_load: assert property (resetPin[*4] |-> activeWord == CFG_RESET)
		else $error("reset pin did not load default");
	// two sync stages on the pin give a two to three cycle window
	a_word_change: assert property (!$stable(activeWord) |->
		$past(endOfConversion) || $past(resetPin, 2) || $past(resetPin, 3))
		else $error("word changed without conversion end");
	a_range_default: assert property (inputRangeSelect == 3'h7 |->
		rangeFullScaleMv == FS_20480) else $error("default range scale wrong");
	a_range_unused: assert property (inputRangeSelect == RANGE_UNUSED |->
		rangeFullScaleMv == FS_NONE) else $error("unused range scale wrong");
	a_range_scope: assert property (rangeAllChannels == (scanMode != SCAN_ADVANCED))
		else $error("range scope wrong");
	a_sense_route: assert property (sourceSelect && pairingSelect |->
		negativeIsSense && positiveInput == channelSelect && !auxSelected)
		else $error("shared sense routing wrong");
	a_pair_route: assert property (sourceSelect && !pairingSelect |->
		!negativeIsSense && positiveInput == {channelSelect[2:1], 1'b0})
		else $error("pair routing wrong");
	a_aux_route: assert property (!sourceSelect |->
		auxSelected && !negativeIsSense && positiveInput == 3'h0) else $error("aux routing wrong");
	a_idle_low: assert property (chipSelectN[*4] |-> !serialOut)
		else $error("output busy while deselected");
	a_pdn_hold: assert property ((powerDownPin && !resetPin)[*3] |=> $stable(activeWord))
		else $error("word moved in power-down");
endmodule
bind adc_config_word_register adc_config_word_checker u_chk (.clock, .resetn, .chipSelectN,
	.serialOut, .resetPin, .powerDownPin, .endOfConversion, .activeWord, .channelSelect,
	.pairingSelect, .positiveInput, .negativeIsSense, .auxSelected, .inputRangeSelect,
	.rangeFullScaleMv, .rangeAllChannels, .sourceSelect, .scanMode);
`default_nettype wire

// [bit_sync.sv]
`timescale 1ns/1ns
`default_nettype none
module bit_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);
	generate
		if (WIDTH < 1) begin : g_bad
			$error("bit_sync width must be at least one");
		end
	endgenerate
	// first stage feeds only the second stage
	logic [WIDTH-1:0] firstStage;
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge clock or negedge resetn) begin
				if (!resetn) begin
					firstStage[i] <= 1'b0;
					syncOut[i] <= 1'b0;
				end else begin
					firstStage[i] <= asyncIn[i];
					syncOut[i] <= firstStage[i];
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// [config_shift_capture.sv]
`timescale 1ns/1ns
`default_nettype none
module config_shift_capture
	import config_word_pkg::*;
(
	input wire logic linkClock,
	input wire logic resetn,
	input wire logic chipSelectN,
	input wire logic serialIn,
	config_shift_if.link bus
);
	logic [4:0] edgeCount;
	logic frameClear;
	// a deselected frame restarts the count; the link clock may stop between frames
	assign frameClear = chipSelectN | ~resetn;
	always_ff @(posedge linkClock or posedge frameClear) begin
		if (frameClear) begin
			edgeCount <= 5'h00;
		end else if (edgeCount < CAPTURE_EDGES) begin
			edgeCount <= edgeCount + 5'h01; // [RULE2]
		end
	end
	// word freezes after sixteen edges so the core can take it safely
	always_ff @(posedge linkClock or negedge resetn) begin
		if (!resetn) begin
			bus.word <= 16'h0000;
		end else if (!chipSelectN && edgeCount < CAPTURE_EDGES) begin
			bus.word <= {bus.word[14:0], serialIn}; // [RULE2]
		end
	end
	always_ff @(posedge linkClock or negedge resetn) begin
		if (!resetn) begin
			bus.wordToggle <= 1'b0;
		end else if (!chipSelectN && edgeCount == CAPTURE_EDGES - 5'h01) begin
			bus.wordToggle <= ~bus.wordToggle; // [RULE2]
		end
	end
endmodule
`default_nettype wire

// [config_shift_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface config_shift_if;
	logic [15:0] word;
	logic wordToggle;
	modport link (output word, output wordToggle);
	modport core (input word, input wordToggle);
endinterface
`default_nettype wire

// [config_word_pkg.sv]
`default_nettype none
package config_word_pkg;
	localparam int CFG_WIDTH = 16;
	localparam int RESULT_WIDTH = 16;
	localparam int SYNC_STAGES = 2;
	localparam logic [15:0] CFG_RESET = 16'h8fcf;
	localparam int UPDATE_BIT = 15;
	localparam int CHAN_HI = 14;
	localparam int CHAN_LO = 12;
	localparam int PAIR_BIT = 11;
	localparam int SPARE_BIT = 10;
	localparam int RANGE_HI = 9;
	localparam int RANGE_LO = 7;
	localparam int SOURCE_BIT = 6;
	localparam int SCAN_HI = 5;
	localparam int SCAN_LO = 4;
	localparam int TEMP_BIT = 3;
	localparam int REF_BIT = 2;
	localparam int CONV_BIT = 1;
	localparam int PHASE_BIT = 0;
	localparam logic [2:0] RANGE_UNUSED = 3'h6;
	localparam logic [1:0] SCAN_ADVANCED = 2'h2;
	localparam logic [14:0] FS_24576 = 15'h6000;
	localparam logic [14:0] FS_10240 = 15'h2800;
	localparam logic [14:0] FS_5120 = 15'h1400;
	localparam logic [14:0] FS_2560 = 15'h0a00;
	localparam logic [14:0] FS_1280 = 15'h0500;
	localparam logic [14:0] FS_640 = 15'h0280;
	localparam logic [14:0] FS_20480 = 15'h5000;
	localparam logic [14:0] FS_NONE = 15'h0000;
	localparam logic [4:0] CAPTURE_EDGES = 5'h10;
	localparam logic [4:0] FRAME_LAST_BIT = 5'h1f;
	typedef enum {LINK_IDLE, LINK_PHASE_HOLD, LINK_SHIFT} readback_state_t;
endpackage
`default_nettype wire

// [host_serial_model.sv]
`timescale 1ns/1ns
`default_nettype none
// ********
// host serial controller
// ********
module host_serial_model (
	output logic linkClock,
	output logic chipSelectN,
	output logic serialIn,
	input wire logic serialOut
);
	logic [31:0] seen;
	initial begin
		linkClock = 0;
		chipSelectN = 1;
		serialIn = 0;
		seen = 0;
	end
	// clock runs only inside a frame; half sets the pace
	task automatic frame(input logic [15:0] w, input int edges, input int half);
		chipSelectN = 0;
		#100;
		for (int i = 0; i < edges; i++) begin
			serialIn = (i < 16) ? w[15 - i] : ~serialIn;
			#(half);
			linkClock = 1;
			#(half);
			seen = {seen[30:0], serialOut};
			linkClock = 0;
		end
		#(half);
		chipSelectN = 1;
		serialIn = ~serialIn; // released line must not keep the last bit
		#100;
	endtask
endmodule
`default_nettype wire

// [testbench.sv]
`timescale 1ns/1ns
`default_nettype none
// ********
// stimulus and checking
// ********
module testbench
	import config_word_pkg::*;
;
	logic clock, resetn, linkClock, chipSelectN, serialIn, serialOut, resetPin, powerDownPin;
	logic endOfConversion, wordPending, pairingSelect, negativeIsSense, auxSelected;
	logic rangeAllChannels, sourceSelect, hasPend;
	logic tempSensorOff, internalReferenceOn, conversionModeSelect, outputPhaseSelect;
	logic [2:0] negativeInput;
	logic [10:0] flds;
	logic [7:0] rt;
	logic [15:0] conversionResult, activeWord, readbackWord, stage, act, rb, lastRes, pend, e, w;
	logic [2:0] channelSelect, positiveInput, inputRangeSelect;
	logic [14:0] rangeFullScaleMv;
	logic [1:0] scanMode;
	logic [15:0] expq[$], rbq[$];
	logic [31:0] rnd, frameExp;
	int miscompares, comparisons;
	adc_config_word_register u_dut (.clock, .resetn, .linkClock, .chipSelectN, .serialIn,
		.serialOut, .resetPin, .powerDownPin, .endOfConversion, .conversionResult, .activeWord,
		.readbackWord, .wordPending, .channelSelect, .pairingSelect, .positiveInput,
		.negativeInput, .negativeIsSense, .auxSelected, .inputRangeSelect, .rangeFullScaleMv,
		.rangeAllChannels, .sourceSelect, .scanMode, .tempSensorOff, .internalReferenceOn,
		.conversionModeSelect, .outputPhaseSelect);
	assign flds = {pairingSelect, inputRangeSelect, sourceSelect, scanMode, tempSensorOff,
		internalReferenceOn, conversionModeSelect, outputPhaseSelect};
	assign rt = {auxSelected, negativeIsSense, positiveInput, negativeInput};
	host_serial_model u_host (.linkClock, .chipSelectN, .serialIn, .serialOut);
	initial begin
		clock = 0;
		forever #5 clock = ~clock;
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	function automatic logic [14:0] scale(input logic [2:0] c);
		case (c)
			3'h0: return FS_24576;
			3'h1: return FS_10240;
			3'h2: return FS_5120;
			3'h3: return FS_2560;
			3'h4: return FS_1280;
			3'h5: return FS_640;
			3'h6: return FS_NONE;
			default: return FS_20480;
		endcase
	endfunction
	// {aux, sense, positive, negative} that a word must route to
	function automatic logic [7:0] route(input logic [15:0] c);
		if (!c[SOURCE_BIT]) return 8'h80;
		if (c[PAIR_BIT]) return {2'b01, c[14:12], 3'h0};
		return {2'b00, c[14:13], 1'b0, c[14:13], 1'b1};
	endfunction
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic end_sim;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// ignored marks a pulse taken during power-down
	task automatic eoc(input logic ignored);
		@(negedge clock);
		rnd = xs(rnd);
		conversionResult = rnd[15:0];
		endOfConversion = 1;
		@(negedge clock);
		endOfConversion = 0;
		if (!ignored) begin
			rb = act;
			lastRes = conversionResult;
			act = stage;
			if (hasPend && pend[UPDATE_BIT]) stage = pend;
			hasPend = 0;
		end
		expq.push_back(act);
		rbq.push_back(rb);
		repeat (4) @(negedge clock);
	endtask
	task automatic wr(input logic [15:0] wd, input int edges, input int half);
		u_host.frame(wd, edges, half);
		if (edges >= 16) begin
			pend = wd;
			hasPend = 1;
		end
	endtask
	always @(posedge clock) begin
		if (resetn && endOfConversion) begin
			repeat (2) @(negedge clock);
			e = expq.pop_front();
			chk("activeWord", activeWord, e);
			chk("channelSelect", channelSelect, e[14:12]);
			chk("rangeFullScaleMv", rangeFullScaleMv, scale(e[9:7]));
			chk("rangeAllChannels", rangeAllChannels, e[5:4] != SCAN_ADVANCED);
			chk("fields", flds, {e[11], e[9:0]});
			chk("routing", rt, route(e));
			chk("readbackWord", readbackWord, rbq.pop_front());
		end
	end
	initial begin
		rnd = 32'h260bd064;
		{resetn, resetPin, powerDownPin, endOfConversion, hasPend} = '0;
		conversionResult = 16'h0000;
		stage = CFG_RESET;
		act = CFG_RESET;
		repeat (8) @(negedge clock);
		resetn = 1;
		repeat (3) @(negedge clock);
		chk("reset word", activeWord, CFG_RESET);
		eoc(0);
		// every channel and range code; one word with the update bit clear
		for (int i = 0; i < 9; i++) begin
			rnd = xs(rnd);
			w = {i != 8, 3'(i), rnd[11:10], 3'(i), rnd[6:1], 1'b0};
			wr(w, 32, 24);
			chk("wordPending", wordPending, 1'b1);
			frameExp = act[PHASE_BIT] ? {lastRes[15], lastRes, rb[15:1]} : {lastRes, rb};
			chk("readback", u_host.seen, frameExp);
			eoc(0);
			chk("wordPending", wordPending, 1'b0);
		end
		wr(16'hc000, 8, 24);
		hasPend = 0;
		chk("short frame", wordPending, 1'b0);
		eoc(0);
		powerDownPin = 1;
		repeat (3) @(negedge clock);
		wr(16'hd6a4, 16, 24);
		eoc(1);
		eoc(1);
		chk("pd pending", wordPending, 1'b1);
		powerDownPin = 0;
		repeat (3) @(negedge clock);
		eoc(0);
		eoc(0);
		resetPin = 1;
		repeat (5) @(negedge clock);
		chk("reset pin word", activeWord, CFG_RESET);
		resetPin = 0;
		repeat (3) @(negedge clock);
		stage = CFG_RESET;
		act = CFG_RESET;
		eoc(0);
		end_sim;
	end
	initial begin
		#300000;
		miscompares++;
		end_sim;
	end
endmodule
`default_nettype wire
